/* File: hw/cbu_pkg.sv */
// Purpose: Shared constants and types of the conditional branch unit
// Assumes: 32-bit registers and addresses, one clock, synchronous reset
// Notes:   Every width, step and limit used by the unit is named here
package cbu_pkg;

    // ------------------------------------------------------------------
    // Widths and field positions
    // ------------------------------------------------------------------
    localparam int unsigned CBU_XLEN     = 32;
    localparam int unsigned CBU_IMM_W    = 16;
    localparam int unsigned CBU_SHIFT    = 2;
    localparam int unsigned CBU_OFS_W    = CBU_IMM_W + CBU_SHIFT;
    localparam int unsigned CBU_REG_W    = 5;
    localparam int unsigned CBU_SIGN_BIT = CBU_XLEN - 1;

    // ------------------------------------------------------------------
    // Address steps, register numbers and reach
    // ------------------------------------------------------------------
    localparam logic [CBU_XLEN-1:0]  CBU_SLOT_STEP = 32'h0000_0004;
    localparam logic [CBU_XLEN-1:0]  CBU_LINK_STEP = 32'h0000_0008;
    localparam logic [CBU_REG_W-1:0] CBU_LINK_REG  = 5'h1f;
    localparam logic [CBU_REG_W-1:0] CBU_ZERO_REG  = 5'h00;
    localparam logic [CBU_XLEN-1:0]  CBU_REACH_MAX = 32'h0001_fffc;
    localparam logic [CBU_XLEN-1:0]  CBU_REACH_MIN = 32'hfffe_0000;
    localparam logic [CBU_XLEN-1:0]  CBU_ZERO_WORD = 32'h0000_0000;

    // Branch kinds handed over by the decoder
    typedef enum logic [2:0] {
        CBU_OP_NONE,
        CBU_OP_BRANCH_EQUAL_LIKELY,
        CBU_OP_BRANCH_NONNEGATIVE,
        CBU_OP_BRANCH_NONNEGATIVE_LIKELY,
        CBU_OP_BRANCH_NONNEGATIVE_CALL,
        CBU_OP_BRANCH_NONNEGATIVE_CALL_LIKELY
    } cbu_op_t;

    // Phase of the unit around a branch
    typedef enum logic {
        CBU_PH_IDLE,
        CBU_PH_SLOT
    } cbu_phase_t;

    // Branch presented by the decoder with its operands read
    typedef struct packed {
        logic                 valid;
        cbu_op_t              op;
        logic [CBU_XLEN-1:0]  pc;
        logic [CBU_IMM_W-1:0] imm;
        logic [CBU_REG_W-1:0] first_source_register;
        logic [CBU_XLEN-1:0]  rs_val;
        logic [CBU_XLEN-1:0]  rt_val;
    } cbu_req_t;

    // Outcome shown during the delay-slot cycle
    typedef struct packed {
        logic                 redirect_valid;
        logic [CBU_XLEN-1:0]  redirect_pc;
        logic                 nullify_slot;
        logic                 link_we;
        logic [CBU_REG_W-1:0] link_idx;
        logic [CBU_XLEN-1:0]  link_data;
    } cbu_resp_t;

    // Whole registered state of the unit
    typedef struct packed {
        cbu_phase_t phase;
        cbu_resp_t  resp;
    } cbu_state_t;

endpackage

/* File: hw/cbu_target_calc.sv */
// Purpose: Address arithmetic for one branch
// Assumes: pc is the address of the branch word itself
// Notes:   Purely combinational, no state
`timescale 1ns/1ps
`default_nettype none

module cbu_target_calc (
    input  wire logic [cbu_pkg::CBU_XLEN-1:0]  pc,
    input  wire logic [cbu_pkg::CBU_IMM_W-1:0] imm,
    output logic      [cbu_pkg::CBU_XLEN-1:0]  slot_pc,
    output logic      [cbu_pkg::CBU_XLEN-1:0]  target_pc,
    output logic      [cbu_pkg::CBU_XLEN-1:0]  link_pc
);

    logic [cbu_pkg::CBU_XLEN-1:0] offset;

    // Offset is the immediate times four, sign-extended
    assign offset = {{(cbu_pkg::CBU_XLEN - cbu_pkg::CBU_OFS_W)
                       {imm[cbu_pkg::CBU_IMM_W-1]}},
                     imm, {cbu_pkg::CBU_SHIFT{1'b0}}};

    // Target is relative to the delay-slot word
    assign slot_pc   = pc + cbu_pkg::CBU_SLOT_STEP;
    assign target_pc = slot_pc + offset;

    // Return address skips branch and delay slot
    assign link_pc   = pc + cbu_pkg::CBU_LINK_STEP;

endmodule

`default_nettype wire

/* File: hw/cbu_branch_unit.sv */
// Purpose: Resolves conditional branches and steers fetch after the slot
// Assumes: Decoder presents one branch with operands; next word is its slot
// Notes:   Outcome appears one cycle after acceptance, for one cycle
`timescale 1ns/1ps
`default_nettype none

module cbu_branch_unit (
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    input  wire cbu_pkg::cbu_req_t req,
    output logic                   req_ready,
    output cbu_pkg::cbu_resp_t     resp
);

    // ------------------------------------------------------------------
    // Address arithmetic
    // ------------------------------------------------------------------
    logic [cbu_pkg::CBU_XLEN-1:0] slot_pc;
    logic [cbu_pkg::CBU_XLEN-1:0] target_pc;
    logic [cbu_pkg::CBU_XLEN-1:0] link_pc;

    cbu_target_calc u_calc (
        .pc        (req.pc),
        .imm       (req.imm),
        .slot_pc   (slot_pc),
        .target_pc (target_pc),
        .link_pc   (link_pc)
    );

    // ------------------------------------------------------------------
    // Condition evaluation
    // ------------------------------------------------------------------
    cbu_pkg::cbu_state_t state_q;
    cbu_pkg::cbu_state_t state_d;
    logic                accept;
    logic                is_likely;
    logic                is_call;
    logic                cond;

    // A branch is only taken while no slot is pending
    assign req_ready = (state_q.phase == cbu_pkg::CBU_PH_IDLE);
    assign accept    = req.valid && req_ready
                       && (req.op != cbu_pkg::CBU_OP_NONE);

    // Kind decoding
    assign is_likely =
        (req.op == cbu_pkg::CBU_OP_BRANCH_EQUAL_LIKELY)
        || (req.op == cbu_pkg::CBU_OP_BRANCH_NONNEGATIVE_LIKELY)
        || (req.op == cbu_pkg::CBU_OP_BRANCH_NONNEGATIVE_CALL_LIKELY);
    assign is_call =
        (req.op == cbu_pkg::CBU_OP_BRANCH_NONNEGATIVE_CALL)
        || (req.op == cbu_pkg::CBU_OP_BRANCH_NONNEGATIVE_CALL_LIKELY);

    // Condition per kind
    always_comb begin
        cond = 1'b0;
        case (req.op)
            cbu_pkg::CBU_OP_BRANCH_EQUAL_LIKELY: begin
                cond = (req.rs_val == req.rt_val);
            end
            cbu_pkg::CBU_OP_BRANCH_NONNEGATIVE,
            cbu_pkg::CBU_OP_BRANCH_NONNEGATIVE_LIKELY: begin
                cond = !req.rs_val[cbu_pkg::CBU_SIGN_BIT];
            end
            cbu_pkg::CBU_OP_BRANCH_NONNEGATIVE_CALL,
            cbu_pkg::CBU_OP_BRANCH_NONNEGATIVE_CALL_LIKELY: begin
                // Zero register makes a plain relative call
                cond = (req.first_source_register == cbu_pkg::CBU_ZERO_REG)
                       || !req.rs_val[cbu_pkg::CBU_SIGN_BIT];
            end
            default: begin
                cond = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Outcome is registered so it acts in the slot cycle
    always_comb begin
        state_d                     = state_q;
        state_d.phase               = cbu_pkg::CBU_PH_IDLE;
        state_d.resp.redirect_valid = 1'b0;
        state_d.resp.nullify_slot   = 1'b0;
        state_d.resp.link_we        = 1'b0;
        case (state_q.phase)
            cbu_pkg::CBU_PH_IDLE: begin
                if (accept) begin
                    state_d.phase               = cbu_pkg::CBU_PH_SLOT;
                    state_d.resp.redirect_valid = cond;
                    state_d.resp.redirect_pc    = target_pc;
                    state_d.resp.nullify_slot   = is_likely
                                                  && !cond;
                    state_d.resp.link_we        = is_call;
                    state_d.resp.link_idx       = cbu_pkg::CBU_LINK_REG;
                    state_d.resp.link_data      = link_pc;
                end
            end
            cbu_pkg::CBU_PH_SLOT: begin
                state_d.phase = cbu_pkg::CBU_PH_IDLE; // Slot consumed
            end
            default: begin
                state_d.phase = cbu_pkg::CBU_PH_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_q.phase               <= cbu_pkg::CBU_PH_IDLE;
            state_q.resp.redirect_valid <= 1'b0;
            state_q.resp.redirect_pc    <= cbu_pkg::CBU_ZERO_WORD;
            state_q.resp.nullify_slot   <= 1'b0;
            state_q.resp.link_we        <= 1'b0;
            state_q.resp.link_idx       <= cbu_pkg::CBU_LINK_REG;
            state_q.resp.link_data      <= cbu_pkg::CBU_ZERO_WORD;
        end else begin
            state_q <= state_d;
        end
    end

    assign resp = state_q.resp;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // Expected values come from $past and package constants, so no extra state here
    a_equal_redirect: assert property (
        accept && req.op == cbu_pkg::CBU_OP_BRANCH_EQUAL_LIKELY
        && req.rs_val == req.rt_val
        |=> resp.redirect_valid && resp.redirect_pc == $past(target_pc)
    ) else $error("equal likely branch did not redirect");

    a_likely_nullify: assert property (
        accept && is_likely && !cond |=> resp.nullify_slot
        && !resp.redirect_valid
    ) else $error("untaken likely branch did not nullify slot");

    a_target_form: assert property (
        accept |=> resp.redirect_pc == $past(req.pc)
        + cbu_pkg::CBU_SLOT_STEP
        + {{(cbu_pkg::CBU_XLEN - cbu_pkg::CBU_OFS_W)
             {$past(req.imm[cbu_pkg::CBU_IMM_W-1])}},
           $past(req.imm), {cbu_pkg::CBU_SHIFT{1'b0}}}
    ) else $error("branch target formed wrongly");

    a_nonneg_taken: assert property (
        accept && req.op == cbu_pkg::CBU_OP_BRANCH_NONNEGATIVE
        |=> resp.redirect_valid == !$past(req.rs_val[cbu_pkg::CBU_SIGN_BIT])
        && !resp.nullify_slot
    ) else $error("non-negative branch decision wrong");

    a_update_delay: assert property (
        accept |-> !resp.redirect_valid ##1 !req_ready ##1 req_ready
        && !resp.redirect_valid
    ) else $error("redirect not confined to the slot cycle");

    a_link_write: assert property (
        accept && is_call |=> resp.link_we
        && resp.link_idx == cbu_pkg::CBU_LINK_REG
        && resp.link_data == $past(req.pc) + cbu_pkg::CBU_LINK_STEP
    ) else $error("call form did not write return link");

    a_reach_bound: assert property (
        resp.redirect_valid
        |-> ($signed(resp.redirect_pc - $past(slot_pc))
             <= $signed(cbu_pkg::CBU_REACH_MAX))
        && ($signed(resp.redirect_pc - $past(slot_pc))
            >= $signed(cbu_pkg::CBU_REACH_MIN))
    ) else $error("redirect outside branch reach");

    a_zero_call: assert property (
        accept && is_call
        && req.first_source_register == cbu_pkg::CBU_ZERO_REG
        |=> resp.redirect_valid
    ) else $error("zero-register call not taken");

    a_full_compare: assert property (
        accept && req.op == cbu_pkg::CBU_OP_BRANCH_EQUAL_LIKELY
        && req.rs_val[cbu_pkg::CBU_SIGN_BIT:cbu_pkg::CBU_IMM_W]
           != req.rt_val[cbu_pkg::CBU_SIGN_BIT:cbu_pkg::CBU_IMM_W]
        |=> !resp.redirect_valid && resp.nullify_slot
    ) else $error("equal compare ignored upper half");

    a_plain_keeps_slot: assert property (
        accept && !is_likely |=> !resp.nullify_slot
    ) else $error("non-likely branch nullified its slot");

    a_likely_taken_slot: assert property (
        accept && is_likely && cond |=> resp.redirect_valid
        && !resp.nullify_slot
    ) else $error("taken likely branch lost its slot");

    a_nonneg_likely: assert property (
        accept && req.op == cbu_pkg::CBU_OP_BRANCH_NONNEGATIVE_LIKELY
        |=> resp.redirect_valid == !$past(req.rs_val[cbu_pkg::CBU_SIGN_BIT])
    ) else $error("non-negative likely decision wrong");

    a_call_sign_test: assert property (
        accept && is_call
        && req.first_source_register != cbu_pkg::CBU_ZERO_REG
        |=> resp.redirect_valid == !$past(req.rs_val[cbu_pkg::CBU_SIGN_BIT])
    ) else $error("call form sign decision wrong");

    c_equal_taken: cover property (
        accept && req.op == cbu_pkg::CBU_OP_BRANCH_EQUAL_LIKELY && cond);
    c_likely_nullified: cover property (
        accept && is_likely && !cond);
    c_call_taken: cover property (
        accept && is_call && cond ##1 resp.link_we);
    c_back_to_back: cover property (
        accept ##2 accept);
    c_nonneg_untaken: cover property (
        accept && req.op == cbu_pkg::CBU_OP_BRANCH_NONNEGATIVE && !cond);

endmodule

`default_nettype wire

/* File: testbench/tb_conditional_branch_unit.sv */
// Purpose: Self-checking bench of the conditional branch unit
// Assumes: Outcome just after the taking edge, for one cycle, spacing of two cycles
// Notes:   Inputs change 1 ns after the rising edge of ref_clk
`timescale 1ns/1ps
`default_nettype none

module tb_conditional_branch_unit;

    // ------------------------------------------------------------------
    // Signals and short names for the branch kinds
    // ------------------------------------------------------------------
    localparam cbu_pkg::cbu_op_t OP_EL = cbu_pkg::CBU_OP_BRANCH_EQUAL_LIKELY;
    localparam cbu_pkg::cbu_op_t OP_NN = cbu_pkg::CBU_OP_BRANCH_NONNEGATIVE;
    localparam cbu_pkg::cbu_op_t OP_NL =
        cbu_pkg::CBU_OP_BRANCH_NONNEGATIVE_LIKELY;
    localparam cbu_pkg::cbu_op_t OP_NC = cbu_pkg::CBU_OP_BRANCH_NONNEGATIVE_CALL;
    localparam cbu_pkg::cbu_op_t OP_CL =
        cbu_pkg::CBU_OP_BRANCH_NONNEGATIVE_CALL_LIKELY;

    logic               ref_clk = 1'b0;
    logic               sys_rst = 1'b1;
    cbu_pkg::cbu_req_t  req     = '0;
    logic               req_ready;
    cbu_pkg::cbu_resp_t resp;
    int                 fails       = 0;
    int                 checks_done = 0;
    int                 cycles      = 0;

    cbu_branch_unit dut (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .req       (req),
        .req_ready (req_ready),
        .resp      (resp)
    );

    // Clock of 25 ns and a ceiling on the run length
    always #12.5 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        cycles = cycles + 1;
        if (cycles == 2000) begin
            fails = fails + 1;
            $display("ERROR %0t run hangs", $time);
            complete_run();
        end
    end

    // ------------------------------------------------------------------
    // Compare, drive and closing tasks
    // ------------------------------------------------------------------
    task automatic chk_bit(input logic got, input logic exp, input string s);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t %s got %b exp %b", $time, s, got, exp);
        end
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp,
                            input string s);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t %s got %h exp %h", $time, s, got, exp);
        end
    endtask

    // One branch: present it, judge the slot cycle and the cycle after
    // Branches come two cycles apart; no slot word is a branch
    task automatic issue(input cbu_pkg::cbu_op_t op, input logic [31:0] pc,
                         input logic [15:0] imm, input logic [4:0] idx,
                         input logic [31:0] rs, input logic [31:0] rt,
                         input logic take, input logic kill, input logic call);
        logic [31:0] tgt;
        tgt = pc + 32'h0000_0004 + {{14{imm[15]}}, imm, 2'b00};
        req = '{1'b1, op, pc, imm, idx, rs, rt};
        @(posedge ref_clk);
        #1;
        req.valid = 1'b0;
        chk_bit(req_ready, 1'b0, "ready in slot");
        chk_bit(resp.redirect_valid, take, "redirect");
        chk_bit(resp.nullify_slot, kill, "nullify");
        chk_bit(resp.link_we, call, "link write");
        if (take) begin
            chk_word(resp.redirect_pc, tgt, "target");
        end
        if (call) begin
            chk_word(resp.link_data, pc + 32'h0000_0008, "link");
            chk_word({27'h0, resp.link_idx}, 32'h0000_001f, "idx");
        end
        @(posedge ref_clk);
        #1;
        chk_bit(resp.redirect_valid | resp.nullify_slot | resp.link_we, 1'b0,
                "pulse length");
        chk_bit(req_ready, 1'b1, "ready after slot");
    endtask

    task automatic complete_run();
        if (fails == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Equal likely taken at most negative offset, then bit 31 differs
    // Likely forms nullify the delay slot when not taken
    task automatic t_equal_likely();
        issue(OP_EL, 32'h0040_0000, 16'h8000, 5'h04, 32'h1234_5678,
              32'h1234_5678, 1'b1, 1'b0, 1'b0);
        issue(OP_EL, 32'h0040_1000, 16'h0001, 5'h04, 32'h8000_0001,
              32'h0000_0001, 1'b0, 1'b1, 1'b0);
    endtask

    // Plain and likely tests of the sign bit, largest forward offset
    task automatic t_nonneg();
        issue(OP_NN, 32'h1000_0000, 16'h7fff, 5'h05, 32'h7fff_ffff,
              32'h0, 1'b1, 1'b0, 1'b0);
        issue(OP_NN, 32'h1000_0100, 16'h0004, 5'h05, 32'h8000_0000,
              32'h0, 1'b0, 1'b0, 1'b0);
        issue(OP_NL, 32'h2000_0000, 16'hfff0, 5'h05, 32'h0000_0000,
              32'h0, 1'b1, 1'b0, 1'b0);
        issue(OP_NL, 32'h2000_0040, 16'h0010, 5'h05, 32'hffff_ffff,
              32'h0, 1'b0, 1'b1, 1'b0);
    endtask

    // Call forms write the link taken or not; zero register always taken
    // No call form tests register 31 as its source
    task automatic t_call();
        issue(OP_NC, 32'h0000_3000, 16'h0020, 5'h06, 32'h8000_0000,
              32'h0, 1'b0, 1'b0, 1'b1);
        issue(OP_NC, 32'h0000_3100, 16'hffff, 5'h00, 32'h8000_0000,
              32'h0, 1'b1, 1'b0, 1'b1);
        issue(OP_CL, 32'h0000_3200, 16'h0008, 5'h07, 32'h0000_0001,
              32'h0, 1'b1, 1'b0, 1'b1);
        issue(OP_CL, 32'h0000_3300, 16'h0008, 5'h07, 32'hffff_fff0,
              32'h0, 1'b0, 1'b1, 1'b1);
    endtask

    // A branch held into its slot cycle is ignored, so is an empty op
    task automatic t_refused();
        req = '{1'b1, OP_NC, 32'h0000_2000, 16'h0010, 5'h03, 32'h0, 32'h0};
        @(posedge ref_clk);
        #1;
        req.pc = 32'h0000_2004;
        @(posedge ref_clk);
        #1;
        req.op = cbu_pkg::CBU_OP_NONE;
        chk_bit(resp.redirect_valid | resp.link_we, 1'b0, "slot");
        @(posedge ref_clk);
        #1;
        req.valid = 1'b0;
        chk_bit(resp.redirect_valid | resp.link_we, 1'b0,
                "none op");
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        @(posedge ref_clk);
        #1;
        chk_bit(req_ready, 1'b1, "ready after reset");
        chk_bit(resp.redirect_valid | resp.link_we, 1'b0,
                "reset pulses");
        chk_word(resp.redirect_pc, 32'h0000_0000, "reset target");
        t_equal_likely();
        t_nonneg();
        t_call();
        t_refused();
        issue(OP_EL, 32'h0000_4000, 16'h0002, 5'h08, 32'h0, 32'h0,
              1'b1, 1'b0, 1'b0);
        complete_run();
    end

endmodule

`default_nettype wire
